// File: acs_conv_timer.sv
// Conversion-cycle timer on the crystal clock, start pulse crossed by toggle
`timescale 1ns/1ps
`default_nettype none
module acs_conv_timer #(
  parameter int CONV_CYCLES = acs_pkg::CONV_XTAL_CYCLES
) (
  input wire logic xtal_clk,
  input wire logic xtal_rst,
  output logic conv_toggle
);
  localparam int CW = $clog2(CONV_CYCLES);
  localparam logic [CW-1:0] LAST = CW'(CONV_CYCLES - 1);
  logic [CW-1:0] cnt_reg;
  wire wrap = (cnt_reg == LAST);
  // A toggle, not a pulse, so the slower side cannot miss a boundary
  always_ff @(posedge xtal_clk or posedge xtal_rst) begin
    if (xtal_rst) begin
      cnt_reg <= '0;
      conv_toggle <= 1'b0;
    end else begin
      cnt_reg <= wrap ? '0 : cnt_reg + 1'b1;
      if (wrap) begin
        conv_toggle <= ~conv_toggle;
      end
    end
  end
endmodule // acs_conv_timer
`default_nettype wire

// File: acs_host_model.sv
// Host controller model: writes the operation-mode field and the command enable bits
`timescale 1ns/1ps
`default_nettype none
module acs_host_model (
  input wire logic clk,
  output logic mode_write,
  output logic [2:0] mode_wdata,
  output logic bias_enable,
  output logic ref_enable
);
  initial begin
    mode_write = 1'b0;
    mode_wdata = 3'h0;
    bias_enable = 1'b1;
    ref_enable = 1'b1;
  end
  // =========================================================
  // Mode write
  // The wake signalling of the serial port is folded into this one write pulse
  task automatic write_mode(input logic [2:0] m);
    @(negedge clk);
    mode_wdata = m;
    mode_write = 1'b1;
    @(negedge clk);
    mode_write = 1'b0;
    // Data is no longer qualified, so show a changed value rather than the last one
    mode_wdata = ~m;
  endtask
  // =========================================================
  // Command enable bits
  task automatic set_enables(input logic b, input logic r);
    @(negedge clk);
    bias_enable = b;
    ref_enable = r;
  endtask
endmodule // acs_host_model
`default_nettype wire

// File: acs_pkg.sv
// Package: constants and types of the calibration and sleep sequencer
package acs_pkg;
  // =========================================================
  // Operation mode encodings
  localparam logic [2:0] MODE_NORMAL = 3'h0;
  localparam logic [2:0] MODE_PSEUDO_CAL = 3'h4;
  localparam logic [2:0] MODE_BG_CAL = 3'h5;
  localparam logic [2:0] MODE_SLEEP = 3'h6;
  // =========================================================
  // Step lengths in conversion periods
  localparam int OFFSET_PERIODS = 3;
  localparam int OFFSET_PERIODS_SLAVE = 4;
  localparam int GAIN_PERIODS = 3;
  localparam int FILL_PERIODS = 3;
  localparam int WAKE_PERIODS = 1;
  // Data rate divisor in background calibration
  localparam int BG_RATE_DIV = 6;
  // =========================================================
  // Timing: crystal clock periods per conversion and power-up time
  localparam int CONV_XTAL_CYCLES = 16;
  localparam int POWERUP_NS = 200;
  localparam int CLK_PERIOD_NS = 25;
  localparam int POWERUP_CYCLES = (POWERUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // Capacitor input routing
  localparam logic [1:0] CAP_INPUT = 2'h0;
  localparam logic [1:0] CAP_SHORT = 2'h1;
  localparam logic [1:0] CAP_REF = 2'h2;
  // =========================================================
  typedef enum logic [3:0] {
    ACS_NORMAL = 4'h0,
    ACS_OFFSET = 4'h1,
    ACS_GAIN = 4'h3,
    ACS_FILL = 4'h2,
    ACS_SLEEP = 4'h6,
    ACS_POWERUP = 4'h7,
    ACS_WAKE = 4'h5,
    ACS_HOLD = 4'h4
  } acs_state_t;
endpackage

// File: acs_sequencer.sv
// Operation-mode sequencer: calibrations, sleep entry and exit
`timescale 1ns/1ps
`default_nettype none
// Overview of operation
// - Mode 100 starts pseudo calibration next cycle
// - Data-ready held high through whole calibration
// - Pseudo offset takes three periods, four slave
// - Then capacitor across reference, three gain conversions
// - Mode cleared, three fill conversions, then ready
// - Mode 101 enters background calibration next cycle
// - Background offset three periods; first slave four
// - Offset, fill three, ready, then gain calibration
// - Gain, fill three, ready, then offset again
// - Background valid results at one sixth rate
// - Background mode persists until host rewrites mode
// - Mode 110 enters sleep until rewritten
// - Sleep powers down; bias and reference keep
// - Slave mode: ordinary command restores communication
// - Sleep exit: power-up, one conversion, then mode
// - Data-ready high through two cycles after sleep
// - Bias and reference not re-enabled at wake
// - Calibration results stored in calibration registers
module acs_sequencer #(
  parameter int CONV_CYCLES = acs_pkg::CONV_XTAL_CYCLES
) (
  input wire logic CLK,
  input wire logic RST,
  input wire logic CRYSTAL_CLOCK,
  input wire logic MODE_WRITE,
  input wire logic [2:0] MODE_WDATA,
  input wire logic SLAVE_MODE,
  input wire logic BIAS_ENABLE,
  input wire logic INTERNAL_REFERENCE_ENABLE,
  input wire logic [23:0] OFFSET_RESULT,
  input wire logic [23:0] GAIN_RESULT,
  output logic [2:0] OPERATION_MODE_FIELD,
  output logic RESULT_VALID_N,
  output logic [1:0] CAP_SELECT,
  output logic ANALOG_POWER_EN,
  output logic BIAS_POWER_EN,
  output logic REF_POWER_EN,
  output logic [23:0] OFFSET_CAL,
  output logic [23:0] FULL_SCALE_CAL,
  output logic CAL_BUSY
);
  // =========================================================
  // Crystal domain: conversion boundaries
  logic xtal_rst_meta_reg;
  logic xtal_rst_reg;
  logic conv_toggle;
  logic conv_toggle_sync;
  logic conv_toggle_prev_reg;
  wire conv_start = conv_toggle_sync ^ conv_toggle_prev_reg;

  // Reset released into the crystal domain synchronously
  always_ff @(posedge CRYSTAL_CLOCK or posedge RST) begin
    if (RST) begin
      xtal_rst_meta_reg <= 1'b1;
      xtal_rst_reg <= 1'b1;
    end else begin
      xtal_rst_meta_reg <= 1'b0;
      xtal_rst_reg <= xtal_rst_meta_reg;
    end
  end

  acs_conv_timer #(.CONV_CYCLES(CONV_CYCLES)) u_timer (
    .xtal_clk(CRYSTAL_CLOCK),
    .xtal_rst(xtal_rst_reg),
    .conv_toggle(conv_toggle)
  );

  acs_sync u_sync (
    .clk(CLK),
    .rst(RST),
    .d(conv_toggle),
    .q(conv_toggle_sync)
  );

  // =========================================================
  // Mode register and pending write
  acs_pkg::acs_state_t state_reg, state_next;
  logic [2:0] mode_reg, mode_next;
  logic pend_reg, pend_next;
  logic is_gain_reg, is_gain_next;
  logic first_off_reg, first_off_next;
  logic [2:0] cnt_reg, cnt_next;
  logic [5:0] pu_cnt_reg, pu_cnt_next;
  logic result_valid_n_n_reg, result_valid_n_n_next;
  logic [1:0] cap_reg, cap_next;
  logic store_off, store_gain;

  wire offset_len_slave = SLAVE_MODE & first_off_reg;
  wire [2:0] offset_last = offset_len_slave ?
    3'(acs_pkg::OFFSET_PERIODS_SLAVE - 1) : 3'(acs_pkg::OFFSET_PERIODS - 1);
  wire [2:0] gain_last = 3'(acs_pkg::GAIN_PERIODS - 1);
  wire [2:0] fill_last = 3'(acs_pkg::FILL_PERIODS - 1);
  wire bg_mode = (mode_reg == acs_pkg::MODE_BG_CAL);
  wire pseudo_mode = (mode_reg == acs_pkg::MODE_PSEUDO_CAL);

  // Tell whether a newly applied mode is one of the two calibration modes
  function automatic logic is_cal(input logic [2:0] m);
    is_cal = (m == acs_pkg::MODE_PSEUDO_CAL) || (m == acs_pkg::MODE_BG_CAL);
  endfunction

  // =========================================================
  // Sequencer
  always_comb begin
    state_next = state_reg;
    mode_next = mode_reg;
    pend_next = pend_reg;
    is_gain_next = is_gain_reg;
    first_off_next = first_off_reg;
    cnt_next = cnt_reg;
    pu_cnt_next = pu_cnt_reg;
    result_valid_n_n_next = result_valid_n_n_reg;
    cap_next = cap_reg;
    store_off = 1'b0;
    store_gain = 1'b0;
    // A write always wins over a hardware clear of the same cycle
    if (MODE_WRITE) begin
      mode_next = MODE_WDATA;
      pend_next = 1'b1;
    end
    case (state_reg)
      acs_pkg::ACS_SLEEP: begin
        if (MODE_WRITE && MODE_WDATA != acs_pkg::MODE_SLEEP) begin
          state_next = acs_pkg::ACS_POWERUP;
          pu_cnt_next = '0;
        end
      end
      acs_pkg::ACS_POWERUP: begin
        pu_cnt_next = pu_cnt_reg + 6'h01;
        if (pu_cnt_reg == 6'(acs_pkg::POWERUP_CYCLES - 1)) begin
          state_next = acs_pkg::ACS_WAKE;
          cnt_next = '0;
        end
      end
      default: begin
        if (conv_start) begin
          result_valid_n_n_next = 1'b1;
          cnt_next = cnt_reg + 3'h1;
          case (state_reg)
            acs_pkg::ACS_WAKE: begin
              // First boundary after power-up opens the one normal conversion
              if (cnt_reg == 3'(acs_pkg::WAKE_PERIODS - 1)) begin
                state_next = acs_pkg::ACS_HOLD;
                cnt_next = '0;
              end
            end
            acs_pkg::ACS_HOLD: begin
              pend_next = 1'b1;
              state_next = acs_pkg::ACS_NORMAL;
            end
            acs_pkg::ACS_OFFSET: begin
              if (cnt_reg == offset_last) begin
                store_off = 1'b1;
                first_off_next = 1'b0;
                cnt_next = '0;
                if (pseudo_mode) begin
                  state_next = acs_pkg::ACS_GAIN;
                  cap_next = acs_pkg::CAP_REF;
                end else begin
                  state_next = acs_pkg::ACS_FILL;
                  is_gain_next = 1'b0;
                  cap_next = acs_pkg::CAP_INPUT;
                end
              end
            end
            acs_pkg::ACS_GAIN: begin
              if (cnt_reg == gain_last) begin
                store_gain = 1'b1;
                state_next = acs_pkg::ACS_FILL;
                is_gain_next = 1'b1;
                cnt_next = '0;
                cap_next = acs_pkg::CAP_INPUT;
                if (pseudo_mode && !MODE_WRITE) begin
                  mode_next = acs_pkg::MODE_NORMAL;
                end
              end
            end
            acs_pkg::ACS_FILL: begin
              if (cnt_reg == fill_last) begin
                cnt_next = '0;
                result_valid_n_n_next = 1'b0;
                if (bg_mode && !is_gain_reg) begin
                  state_next = acs_pkg::ACS_GAIN;
                  cap_next = acs_pkg::CAP_REF;
                end else if (bg_mode) begin
                  state_next = acs_pkg::ACS_OFFSET;
                  cap_next = acs_pkg::CAP_SHORT;
                end else begin
                  state_next = acs_pkg::ACS_NORMAL;
                end
              end
            end
            default: begin
              result_valid_n_n_next = 1'b0;
            end
          endcase
          // A pending mode takes effect at a conversion boundary
          if (pend_reg && state_next == acs_pkg::ACS_NORMAL) begin
            pend_next = MODE_WRITE;
            cnt_next = '0;
            if (mode_next == acs_pkg::MODE_SLEEP) begin
              state_next = acs_pkg::ACS_SLEEP;
              result_valid_n_n_next = 1'b1;
            end else if (is_cal(mode_next)) begin
              state_next = acs_pkg::ACS_OFFSET;
              first_off_next = 1'b1;
              result_valid_n_n_next = 1'b1;
              cap_next = (mode_next == acs_pkg::MODE_BG_CAL) ?
                acs_pkg::CAP_SHORT : acs_pkg::CAP_INPUT;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      state_reg <= acs_pkg::ACS_NORMAL;
      mode_reg <= acs_pkg::MODE_NORMAL;
      pend_reg <= 1'b0;
      is_gain_reg <= 1'b0;
      first_off_reg <= 1'b0;
      cnt_reg <= '0;
      pu_cnt_reg <= '0;
      result_valid_n_n_reg <= 1'b1;
      cap_reg <= acs_pkg::CAP_INPUT;
      conv_toggle_prev_reg <= 1'b0;
    end else begin
      state_reg <= state_next;
      mode_reg <= mode_next;
      pend_reg <= pend_next;
      is_gain_reg <= is_gain_next;
      first_off_reg <= first_off_next;
      cnt_reg <= cnt_next;
      pu_cnt_reg <= pu_cnt_next;
      result_valid_n_n_reg <= result_valid_n_n_next;
      cap_reg <= cap_next;
      conv_toggle_prev_reg <= conv_toggle_sync;
    end
  end

  // Calibration results are kept until the next calibration overwrites them
  always_ff @(posedge CLK or posedge RST) begin
    if (RST) begin
      OFFSET_CAL <= '0;
      FULL_SCALE_CAL <= '0;
    end else begin
      if (store_off) begin
        OFFSET_CAL <= OFFSET_RESULT;
      end
      if (store_gain) begin
        FULL_SCALE_CAL <= GAIN_RESULT;
      end
    end
  end

  // =========================================================
  // Outputs
  wire asleep = (state_reg == acs_pkg::ACS_SLEEP);
  assign OPERATION_MODE_FIELD = mode_reg;
  assign RESULT_VALID_N = result_valid_n_n_reg;
  assign CAP_SELECT = cap_reg;
  assign ANALOG_POWER_EN = ~asleep;
  // Bias and reference follow only their own enables, never the wake
  assign BIAS_POWER_EN = BIAS_ENABLE;
  assign REF_POWER_EN = INTERNAL_REFERENCE_ENABLE;
  assign CAL_BUSY = (state_reg == acs_pkg::ACS_OFFSET) || (state_reg == acs_pkg::ACS_GAIN);

  // =========================================================
  // Assertions
  a_cal_ready_high: assert property (@(posedge CLK) disable iff (RST)
    (CAL_BUSY && (pseudo_mode || first_off_reg)) |-> RESULT_VALID_N)
    else $error("Data ready low during calibration");
  a_sleep_ready_high: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == acs_pkg::ACS_WAKE || state_reg == acs_pkg::ACS_POWERUP ||
     state_reg == acs_pkg::ACS_HOLD) |-> RESULT_VALID_N)
    else $error("Data ready low during sleep exit");
  a_sleep_analog_off: assert property (@(posedge CLK) disable iff (RST)
    asleep |-> !ANALOG_POWER_EN && mode_reg == acs_pkg::MODE_SLEEP)
    else $error("Sleep power state wrong");
  a_bg_mode_kept: assert property (@(posedge CLK) disable iff (RST)
    (bg_mode && !MODE_WRITE) |=> bg_mode)
    else $error("Background mode cleared by itself");
  a_pseudo_clears: assert property (@(posedge CLK) disable iff (RST)
    (store_gain && pseudo_mode && !MODE_WRITE) |=> mode_reg == acs_pkg::MODE_NORMAL)
    else $error("Pseudo calibration did not clear mode");
  a_gain_on_ref: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == acs_pkg::ACS_GAIN) |-> CAP_SELECT == acs_pkg::CAP_REF)
    else $error("Gain step not across reference");
  a_bg_short_off: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == acs_pkg::ACS_OFFSET && bg_mode) |-> CAP_SELECT == acs_pkg::CAP_SHORT)
    else $error("Background offset not shorted");
  a_offset_store: assert property (@(posedge CLK) disable iff (RST)
    store_off |=> OFFSET_CAL == $past(OFFSET_RESULT))
    else $error("Offset result not stored");
  a_fill_ready_high: assert property (@(posedge CLK) disable iff (RST)
    (state_reg == acs_pkg::ACS_FILL) |-> RESULT_VALID_N)
    else $error("Data ready low while filling");
endmodule // acs_sequencer
`default_nettype wire

// File: acs_sync.sv
// Two-flop level synchroniser
`timescale 1ns/1ps
`default_nettype none
module acs_sync (
  input wire logic clk,
  input wire logic rst,
  input wire logic d,
  output logic q
);
  logic meta_reg;
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      meta_reg <= 1'b0;
      q <= 1'b0;
    end else begin
      meta_reg <= d;
      q <= meta_reg;
    end
  end
endmodule // acs_sync
`default_nettype wire

// File: adc_calibration_sleep_sequencer_bench.sv
// Self-checking bench of the calibration and sleep sequencer
`timescale 1ns/1ps
`default_nettype none
module adc_calibration_sleep_sequencer_bench;
  typedef struct {
    logic [2:0] mode;
    logic slave;
    int span;
    logic [1:0] cap;
  } acs_row_t;
  localparam int CONV = 32;
  localparam real CONV_NS = CONV * 6.0;
  logic clk = 1'b0;
  logic xclk = 1'b0;
  logic rst = 1'b1;
  logic slave_mode = 1'b0;
  logic [23:0] off_res = 24'h000000;
  logic [23:0] gain_res = 24'h000000;
  logic mode_write, bias_enable, ref_enable;
  logic [2:0] mode_wdata, op_field;
  logic result_valid_n, analog_power_en, bias_power_en, ref_power_en, cal_busy;
  logic [1:0] cap_select;
  logic [23:0] offset_cal, full_scale_cal;
  logic [1:0] sel = 2'h0;
  int err_total = 0;
  int checks_done = 0;
  realtime t0, t1, t2, t4, t5;
  wire logic watched = (sel == 2'h0) ? cal_busy : (sel == 2'h1) ? result_valid_n : analog_power_en;
  acs_row_t rows [4] = '{
    '{acs_pkg::MODE_PSEUDO_CAL, 1'b0, 6, acs_pkg::CAP_INPUT},
    '{acs_pkg::MODE_PSEUDO_CAL, 1'b1, 7, acs_pkg::CAP_INPUT},
    '{acs_pkg::MODE_BG_CAL, 1'b0, 3, acs_pkg::CAP_SHORT},
    '{acs_pkg::MODE_BG_CAL, 1'b1, 4, acs_pkg::CAP_SHORT}};
  // =========================================================
  // Clocks, design and host
  always #12.5 clk = ~clk;
  always #3 xclk = ~xclk;
  acs_sequencer #(.CONV_CYCLES(CONV)) dut_u (
    .CLK(clk), .RST(rst), .CRYSTAL_CLOCK(xclk), .MODE_WRITE(mode_write),
    .MODE_WDATA(mode_wdata), .SLAVE_MODE(slave_mode), .BIAS_ENABLE(bias_enable),
    .INTERNAL_REFERENCE_ENABLE(ref_enable), .OFFSET_RESULT(off_res), .GAIN_RESULT(gain_res),
    .OPERATION_MODE_FIELD(op_field), .RESULT_VALID_N(result_valid_n), .CAP_SELECT(cap_select),
    .ANALOG_POWER_EN(analog_power_en), .BIAS_POWER_EN(bias_power_en),
    .REF_POWER_EN(ref_power_en), .OFFSET_CAL(offset_cal), .FULL_SCALE_CAL(full_scale_cal),
    .CAL_BUSY(cal_busy));
  acs_host_model host_u (
    .clk(clk), .mode_write(mode_write), .mode_wdata(mode_wdata),
    .bias_enable(bias_enable), .ref_enable(ref_enable));
  // =========================================================
  // Helpers
  task automatic tally_and_finish();
    $display("mismatches %0d, comparisons %0d", err_total, checks_done);
    if (err_total == 0 && checks_done > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic check(input logic ok, input string msg);
    checks_done++;
    if (ok !== 1'b1) begin
      err_total++;
      $display("CHECK FAILED at %0t: %s", $time, msg);
    end
  endtask
  // Durations are measured in time because boundaries drift against CLK
  function automatic int convs(input realtime d);
    return $rtoi(d / CONV_NS + 0.5);
  endfunction
  task automatic wait_for(input logic [1:0] s, input logic v, output realtime t);
    sel = s;
    for (int i = 0; i < 4000; i++) begin
      @(posedge clk);
      #1;
      if (watched === v) begin
        t = $realtime;
        return;
      end
    end
    check(1'b0, "wait ran out");
    tally_and_finish();
  endtask
  task automatic do_reset();
    @(negedge clk);
    rst = 1'b1;
    repeat (5) @(negedge clk);
    rst = 1'b0;
  endtask
  // =========================================================
  // Main sequence
  initial begin
    repeat (3) @(negedge clk);
    check(op_field === 3'h0 && result_valid_n === 1'b1 && cap_select === 2'h0, "reset state");
    check(offset_cal === 24'h000000 && full_scale_cal === 24'h000000, "reset cal regs");
    for (int r = 0; r < 4; r++) begin
      do_reset();
      slave_mode = rows[r].slave;
      off_res = 24'h0a0b00 + 24'(r);
      gain_res = 24'h70c000 + 24'(r);
      host_u.write_mode(rows[r].mode);
      wait_for(2'h0, 1'b1, t0);
      repeat (2) @(posedge clk);
      #1;
      check(cap_select === rows[r].cap, "capacitor routing at offset");
      check(result_valid_n === 1'b1, "ready high in offset step");
      wait_for(2'h0, 1'b0, t1);
      check(convs(t1 - t0) == rows[r].span, "first step length");
      wait_for(2'h1, 1'b0, t2);
      check(convs(t2 - t1) == 3, "fill length");
      if (rows[r].mode === acs_pkg::MODE_PSEUDO_CAL) begin
        check(op_field === acs_pkg::MODE_NORMAL, "field cleared");
        check(offset_cal === off_res, "offset stored");
        check(full_scale_cal === gain_res, "full scale stored");
      end else begin
        repeat (2) @(posedge clk);
        #1;
        check(cap_select === acs_pkg::CAP_REF && cal_busy === 1'b1, "gain step");
        wait_for(2'h0, 1'b0, t4);
        check(convs(t4 - t2) == 3, "gain length");
        wait_for(2'h1, 1'b1, t5);
        wait_for(2'h1, 1'b0, t5);
        check(convs(t5 - t2) == acs_pkg::BG_RATE_DIV, "valid spacing");
        repeat (2) @(posedge clk);
        #1;
        check(cap_select === acs_pkg::CAP_SHORT, "offset again");
        check(op_field === acs_pkg::MODE_BG_CAL, "mode kept");
        check(offset_cal === off_res && full_scale_cal === gain_res, "cal stored");
      end
    end
    // Sleep entry, disabled bias across the sleep, wake to normal
    do_reset();
    host_u.write_mode(acs_pkg::MODE_SLEEP);
    wait_for(2'h2, 1'b0, t0);
    host_u.set_enables(1'b0, 1'b1);
    repeat (40) @(posedge clk);
    #1;
    check(analog_power_en === 1'b0 && op_field === acs_pkg::MODE_SLEEP, "stays asleep");
    check(ref_power_en === 1'b1 && bias_power_en === 1'b0, "enables follow bits");
    host_u.write_mode(acs_pkg::MODE_NORMAL);
    wait_for(2'h2, 1'b1, t1);
    wait_for(2'h1, 1'b0, t2);
    check(t2 - t1 >= 2.0 * CONV_NS - 50.0, "two conversions high");
    // Power-up, a part cycle to the first boundary, then two full conversions
    check(convs(t2 - t1) <= 4, "wake too slow");
    check(bias_power_en === 1'b0, "bias left off");
    host_u.set_enables(1'b1, 1'b1);
    repeat (2) @(posedge clk);
    #1;
    check(bias_power_en === 1'b1, "bias back on");
    tally_and_finish();
  end
endmodule // adc_calibration_sleep_sequencer_bench
`default_nettype wire
